// >>> gpib_iface_pkg.sv
// Purpose: Shared constants and enumerations for the bus listen/talk interface
// Assumes: 100 MHz clk, AHB-Lite register access, 32-bit data
// Notes:   Bus command codes are 7-bit values; bit 7 of a command byte is ignored

package gpib_iface_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] RXDATA_OFF = 8'h08;

	// Control register fields
	localparam int         CTRL_ADDR_LSB = 0;
	localparam int         CTRL_ADDR_W   = 5;
	localparam int         CTRL_EN_BIT   = 8;
	localparam logic [4:0] ADDR_RST      = 5'h01;
	localparam logic       ENABLE_RST    = 1'b1;

	// Status register fields
	localparam int STAT_MEM_LSB  = 0;
	localparam int STAT_POLL_BIT = 2;
	localparam int STAT_LSEL_BIT = 3;
	localparam int STAT_TSEL_BIT = 4;
	localparam int STAT_CMD_LSB  = 8;

	// AHB encodings
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ----------------------------------------------------------------
	// Bus commands
	// ----------------------------------------------------------------
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK   = 2'h2;
	localparam logic [6:0] CMD_UNL    = 7'h3F;
	localparam logic [6:0] CMD_UNT    = 7'h5F;
	localparam logic [6:0] CMD_SPE    = 7'h18;
	localparam logic [6:0] CMD_SPD    = 7'h19;

	// Remembered interface state
	typedef enum logic [1:0] {
		MEM_IDLE,
		MEM_LISTEN,
		MEM_TALK,
		MEM_POLL
	} mem_e;

	// Bus handshake sequencer
	typedef enum logic [3:0] {
		HS_OFF,
		HS_L_WAIT,
		HS_L_READY,
		HS_L_GRAB,
		HS_L_ACCEPT,
		HS_T_WAIT,
		HS_T_VALID,
		HS_T_SENT,
		HS_T_GAP
	} hs_e;

endpackage

// >>> gpib_iface.sv
// Purpose: Listen/talk/poll interface between a three-wire handshake bus and a peripheral
// Assumes: All bus lines are open-drain, low true; peripheral strobes are levels
// Notes:   Every bus pin and peripheral strobe passes a two-stage synchroniser first

`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - ATN low makes the interface at once ready to accept command bytes.
// - Under ATN every controller byte is handshaken and passed to the decoder.
// - A valid decoded address is remembered and taken on when ATN releases.
// - After power-up the remembered state is IDLE.
// - Own talk address selects TALK, listen address LISTEN, SPE selects POLL from IDLE.
// - UNLISTEN or SPD under ATN returns the matching state to IDLE; UNTALK returns to POLL if a poll is recorded, else IDLE.
// - IFC low forces IDLE from any state.
// - LISTEN with ATN high raises listen_select and joins peripheral strobes in.
// - While peripheral_hold is set wait; once clear, release NRFD high.
// - DAV low during listening raises capture_strobe for the peripheral.
// - capture_done from the peripheral releases NDAC high.
// - After acceptance the interface pulls NDAC low again for the next byte.
// - UNLISTEN returns memory from LISTEN to IDLE; listen_select already dropped when ATN went low.
// - Under ATN all peripheral handshake inputs are ignored.
// - ATN release with TALK remembered raises talk_select.
// - Data drivers and talk handshake work only while talk_select is set.
// - DAV is pulled low only when NRFD is high and byte_ready is set.
// - NDAC high in talking returns DAV high, then pulses byte_sent.
// - SPE records a poll in progress and raises poll_active.
// - While service_request_in is set the SRQ line is pulled low.
module gpib_iface (
	input  wire logic        clk,
	input  wire logic        rst_n,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Bus control inputs, low true
	input  wire logic        atn_n,
	input  wire logic        ifc_n,
	// Bus open-drain lines, low true
	input  wire logic        dav_n_in,
	output logic             dav_n_out,
	output logic             dav_n_oe,
	input  wire logic        nrfd_n_in,
	output logic             nrfd_n_out,
	output logic             nrfd_n_oe,
	input  wire logic        ndac_n_in,
	output logic             ndac_n_out,
	output logic             ndac_n_oe,
	input  wire logic [7:0]  dio_n_in,
	output logic [7:0]       dio_n_out,
	output logic             dio_n_oe,
	output logic             srq_n_out,
	output logic             srq_n_oe,
	// Peripheral side
	output logic             listen_select,
	output logic             talk_select,
	output logic             poll_active,
	output logic [7:0]       in_data,
	output logic             capture_strobe,
	input  wire logic        capture_done,
	input  wire logic        peripheral_hold,
	input  wire logic [7:0]  out_data,
	input  wire logic        byte_ready,
	output logic             byte_sent,
	input  wire logic        service_request_in
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]          atn_s;
		logic [1:0]          ifc_s;
		logic [1:0]          dav_s;
		logic [1:0]          nrfd_s;
		logic [1:0]          ndac_s;
		logic [1:0]          hold_s;
		logic [1:0]          done_s;
		logic [1:0]          ready_s;
		logic [1:0]          srq_s;
		logic [7:0]          dio_s1;
		logic [7:0]          dio_s2;
		gpib_iface_pkg::mem_e mem;
		logic                poll;
		gpib_iface_pkg::hs_e  hs;
		logic [7:0]          rx_data;
		logic [7:0]          last_cmd;
		logic                grab;
		logic                sent;
		logic                lsel;
		logic                tsel;
		logic                srq_pull;
		logic                dav_pull;
		logic                nrfd_pull;
		logic                ndac_pull;
		logic [7:0]          dio_val;
		logic [4:0]          my_addr;
		logic                enable;
		logic                wr_ctrl;
		logic [31:0]         rdata;
	} state_s;

	state_s r;
	state_s n;

	// Synchronised views, asserted-high
	logic       atn_a;
	logic       ifc_a;
	logic       dav_a;
	logic       nrfd_hi;
	logic       ndac_hi;
	logic       hold_a;
	logic       done_a;
	logic       ready_a;
	logic       listen_on;
	logic       talk_on;
	logic       bus_take;
	logic [6:0] cmd;

	assign atn_a     = ~r.atn_s[1];
	assign ifc_a     = ~r.ifc_s[1];
	assign dav_a     = ~r.dav_s[1];
	assign nrfd_hi   = r.nrfd_s[1];
	assign ndac_hi   = r.ndac_s[1];
	assign hold_a    = r.hold_s[1];
	assign done_a    = r.done_s[1];
	assign ready_a   = r.ready_s[1];
	assign listen_on = r.enable && !atn_a && (r.mem == gpib_iface_pkg::MEM_LISTEN);
	assign talk_on   = r.enable && !atn_a && (r.mem == gpib_iface_pkg::MEM_TALK);
	assign bus_take  = hsel && hready && htrans[1] && (hsize == gpib_iface_pkg::HSIZE_WORD);
	assign cmd       = r.rx_data[6:0];

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		n = r;

		// Two-stage synchronisers; only stage 1 reads stage 0
		n.atn_s   = {r.atn_s[0], atn_n};
		n.ifc_s   = {r.ifc_s[0], ifc_n};
		n.dav_s   = {r.dav_s[0], dav_n_in};
		n.nrfd_s  = {r.nrfd_s[0], nrfd_n_in};
		n.ndac_s  = {r.ndac_s[0], ndac_n_in};
		n.hold_s  = {r.hold_s[0], peripheral_hold};
		n.done_s  = {r.done_s[0], capture_done};
		n.ready_s = {r.ready_s[0], byte_ready};
		n.srq_s   = {r.srq_s[0], service_request_in};
		n.dio_s1  = dio_n_in;
		n.dio_s2  = r.dio_s1;

		// Handshake sequencer
		case (r.hs)
			gpib_iface_pkg::HS_OFF: begin
				if (r.enable && (atn_a || listen_on)) begin
					n.hs = gpib_iface_pkg::HS_L_WAIT;
				end else if (talk_on) begin
					n.hs = gpib_iface_pkg::HS_T_WAIT;
				end
			end
			gpib_iface_pkg::HS_L_WAIT: begin
				// Hold is only looked at while ATN is high
				if (atn_a || (listen_on && !hold_a)) begin
					n.hs = gpib_iface_pkg::HS_L_READY;
				end else if (!listen_on) begin
					n.hs = gpib_iface_pkg::HS_OFF;
				end
			end
			gpib_iface_pkg::HS_L_READY: begin
				if (!atn_a && !listen_on) begin
					n.hs = gpib_iface_pkg::HS_OFF;
				end else if (dav_a) begin
					n.hs      = gpib_iface_pkg::HS_L_GRAB;
					n.rx_data = ~r.dio_s2;                                 // Lines are low true
				end else if (!atn_a && hold_a) begin
					n.hs = gpib_iface_pkg::HS_L_WAIT;
				end
			end
			gpib_iface_pkg::HS_L_GRAB: begin
				if (atn_a) begin
					n.hs       = gpib_iface_pkg::HS_L_ACCEPT;
					n.last_cmd = r.rx_data;
				end else if (!listen_on) begin
					n.hs = gpib_iface_pkg::HS_OFF;
				end else if (done_a) begin
					n.hs = gpib_iface_pkg::HS_L_ACCEPT;
				end
			end
			gpib_iface_pkg::HS_L_ACCEPT: begin
				// Re-arm NDAC once the talker withdraws DAV
				if (!dav_a) begin
					n.hs = gpib_iface_pkg::HS_L_WAIT;
				end
			end
			gpib_iface_pkg::HS_T_WAIT: begin
				if (atn_a) begin
					n.hs = gpib_iface_pkg::HS_L_WAIT;
				end else if (!talk_on) begin
					n.hs = gpib_iface_pkg::HS_OFF;
				end else if (nrfd_hi && ready_a) begin
					n.hs = gpib_iface_pkg::HS_T_VALID;
				end
			end
			gpib_iface_pkg::HS_T_VALID: begin
				if (atn_a) begin
					n.hs = gpib_iface_pkg::HS_L_WAIT;
				end else if (ndac_hi) begin
					n.hs = gpib_iface_pkg::HS_T_SENT;
				end
			end
			gpib_iface_pkg::HS_T_SENT: begin
				n.hs = gpib_iface_pkg::HS_T_GAP;
			end
			gpib_iface_pkg::HS_T_GAP: begin
				// Wait for the peripheral to drop byte_ready before the next byte
				if (atn_a) begin
					n.hs = gpib_iface_pkg::HS_L_WAIT;
				end else if (!ready_a || !talk_on) begin
					n.hs = gpib_iface_pkg::HS_T_WAIT;
				end
			end
			default: begin
				n.hs = gpib_iface_pkg::HS_OFF;
			end
		endcase

		// Command decode on each byte accepted under ATN
		if (r.hs == gpib_iface_pkg::HS_L_GRAB && atn_a) begin
			if (cmd == {gpib_iface_pkg::GRP_LISTEN, r.my_addr}) begin
				n.mem = gpib_iface_pkg::MEM_LISTEN;
			end else if (cmd == {gpib_iface_pkg::GRP_TALK, r.my_addr}) begin
				n.mem = gpib_iface_pkg::MEM_TALK;
			end else if (cmd == gpib_iface_pkg::CMD_UNL) begin
				if (r.mem == gpib_iface_pkg::MEM_LISTEN) begin
					n.mem = gpib_iface_pkg::MEM_IDLE;
				end
			end else if (cmd == gpib_iface_pkg::CMD_SPE) begin
				n.poll = 1'b1;
				if (r.mem == gpib_iface_pkg::MEM_IDLE) begin
					n.mem = gpib_iface_pkg::MEM_POLL;
				end
			end else if (cmd == gpib_iface_pkg::CMD_SPD) begin
				n.poll = 1'b0;
				if (r.mem == gpib_iface_pkg::MEM_POLL) begin
					n.mem = gpib_iface_pkg::MEM_IDLE;
				end
			end else if (cmd[6:5] == gpib_iface_pkg::GRP_TALK
					&& r.mem == gpib_iface_pkg::MEM_TALK) begin
				// Untalk, or another talk address taken as an implied untalk
				n.mem = r.poll ? gpib_iface_pkg::MEM_POLL : gpib_iface_pkg::MEM_IDLE;
			end
		end

		// Interface clear and disable override everything
		if (ifc_a || !r.enable) begin
			n.mem  = gpib_iface_pkg::MEM_IDLE;
			n.poll = 1'b0;
			n.hs   = gpib_iface_pkg::HS_OFF;
		end

		// Registered pin and peripheral drives; the handshake pulls and capture_strobe are derived from the next state
		n.nrfd_pull = (n.hs == gpib_iface_pkg::HS_L_WAIT) || (n.hs == gpib_iface_pkg::HS_L_GRAB)
			|| (n.hs == gpib_iface_pkg::HS_L_ACCEPT);
		n.ndac_pull = (n.hs == gpib_iface_pkg::HS_L_WAIT) || (n.hs == gpib_iface_pkg::HS_L_READY)
			|| (n.hs == gpib_iface_pkg::HS_L_GRAB);
		n.dav_pull  = (n.hs == gpib_iface_pkg::HS_T_VALID);
		n.grab      = (n.hs == gpib_iface_pkg::HS_L_GRAB) && !atn_a;
		n.sent      = (r.hs == gpib_iface_pkg::HS_T_SENT);
		n.lsel      = listen_on && !ifc_a;
		n.tsel      = talk_on && !ifc_a;
		n.dio_val   = ~out_data;
		n.srq_pull  = r.srq_s[1];

		// AHB-Lite data phase write, then address phase capture
		if (r.wr_ctrl) begin
			n.my_addr = hwdata[gpib_iface_pkg::CTRL_ADDR_LSB +: gpib_iface_pkg::CTRL_ADDR_W];
			n.enable  = hwdata[gpib_iface_pkg::CTRL_EN_BIT];
		end
		n.wr_ctrl = bus_take && hwrite && (haddr[7:0] == gpib_iface_pkg::CTRL_OFF) && (haddr[31:8] == 24'h000000);
		if (bus_take && !hwrite) begin
			n.rdata = 32'h00000000;                                          // Unmapped reads as zero
			if (haddr[31:8] == 24'h000000) begin
				case (haddr[7:0])
					gpib_iface_pkg::CTRL_OFF: begin
						n.rdata[gpib_iface_pkg::CTRL_ADDR_LSB +: gpib_iface_pkg::CTRL_ADDR_W] = r.my_addr;
						n.rdata[gpib_iface_pkg::CTRL_EN_BIT] = r.enable;
					end
					gpib_iface_pkg::STATUS_OFF: begin
						n.rdata[gpib_iface_pkg::STAT_MEM_LSB +: 2] = r.mem;
						n.rdata[gpib_iface_pkg::STAT_POLL_BIT]     = r.poll;
						n.rdata[gpib_iface_pkg::STAT_LSEL_BIT]     = r.lsel;
						n.rdata[gpib_iface_pkg::STAT_TSEL_BIT]     = r.tsel;
						n.rdata[gpib_iface_pkg::STAT_CMD_LSB +: 8] = r.last_cmd;
					end
					gpib_iface_pkg::RXDATA_OFF: begin
						n.rdata[7:0] = r.rx_data;
					end
					default: begin
						n.rdata = 32'h00000000;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Idle lines reset high so no false edge is seen after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r          <= '0;
			r.atn_s    <= 2'h3;
			r.ifc_s    <= 2'h3;
			r.dav_s    <= 2'h3;
			r.nrfd_s   <= 2'h3;
			r.ndac_s   <= 2'h3;
			r.dio_s1   <= 8'hFF;
			r.dio_s2   <= 8'hFF;
			r.mem      <= gpib_iface_pkg::MEM_IDLE;
			r.hs       <= gpib_iface_pkg::HS_OFF;
			r.dio_val  <= 8'hFF;
			r.my_addr  <= gpib_iface_pkg::ADDR_RST;
			r.enable   <= gpib_iface_pkg::ENABLE_RST;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open-drain pins only ever pull low
	assign dav_n_out      = 1'b0;
	assign dav_n_oe       = r.dav_pull;
	assign nrfd_n_out     = 1'b0;
	assign nrfd_n_oe      = r.nrfd_pull;
	assign ndac_n_out     = 1'b0;
	assign ndac_n_oe      = r.ndac_pull;
	assign srq_n_out      = 1'b0;
	assign srq_n_oe       = r.srq_pull;
	assign dio_n_out      = r.dio_val;
	assign dio_n_oe       = r.tsel;
	assign listen_select  = r.lsel;
	assign talk_select    = r.tsel;
	assign poll_active    = r.poll;
	assign in_data        = r.rx_data;
	assign capture_strobe = r.grab;
	assign byte_sent      = r.sent;
	assign hreadyout      = 1'b1;                                             // Zero wait states
	assign hresp          = 1'b0;
	assign hrdata         = r.rdata;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_talk_valid_ack;
		r.hs == gpib_iface_pkg::HS_T_VALID && !atn_a && ndac_hi && !ifc_a && r.enable;
	endsequence

	sequence s_dav_release_then_sent;
		!r.dav_pull ##1 r.sent;
	endsequence

	AST_ATN_READY: assert property ((atn_a && !ifc_a && r.enable && r.hs == gpib_iface_pkg::HS_L_WAIT) |=> (r.hs == gpib_iface_pkg::HS_L_READY && !r.nrfd_pull)) else $error("ATN did not make the interface ready");
	AST_CMD_DECODE: assert property ((atn_a && !ifc_a && r.enable && r.hs == gpib_iface_pkg::HS_L_GRAB) |=> (r.hs == gpib_iface_pkg::HS_L_ACCEPT && r.last_cmd == $past(r.rx_data))) else $error("Command byte not passed to decoder");
	AST_TALK_ENTER: assert property ((!atn_a && r.enable && !ifc_a && r.mem == gpib_iface_pkg::MEM_TALK) ##1 (!atn_a && !ifc_a && r.mem == gpib_iface_pkg::MEM_TALK) |-> talk_select) else $error("Talk select missing after ATN release");
	AST_IFC_IDLE: assert property (ifc_a |=> (r.mem == gpib_iface_pkg::MEM_IDLE && !r.poll && !r.lsel && !r.tsel)) else $error("IFC did not force idle");
	AST_HOLD_WAIT: assert property ((r.hs == gpib_iface_pkg::HS_L_WAIT && !atn_a && !ifc_a && r.enable && hold_a && r.mem == gpib_iface_pkg::MEM_LISTEN) |=> r.nrfd_pull) else $error("NRFD released while peripheral holds");
	AST_GRAB_ON_DAV: assert property ((r.hs == gpib_iface_pkg::HS_L_READY && listen_on && dav_a && !ifc_a) |=> capture_strobe ##1 (capture_strobe || r.hs != gpib_iface_pkg::HS_L_GRAB)) else $error("capture_strobe not raised on DAV");
	AST_DONE_NDAC: assert property ((r.hs == gpib_iface_pkg::HS_L_GRAB && listen_on && done_a && !ifc_a) |=> (!r.ndac_pull && r.nrfd_pull)) else $error("NDAC not released on capture_done");
	AST_NDAC_REARM: assert property ((r.hs == gpib_iface_pkg::HS_L_ACCEPT && !dav_a && !ifc_a && r.enable) |=> r.ndac_pull) else $error("NDAC not pulled low again");
	AST_DAV_COND: assert property ($rose(r.dav_pull) |-> $past(nrfd_hi && ready_a)) else $error("DAV pulled without NRFD high and byte_ready");
	AST_SENT_ORDER: assert property (s_talk_valid_ack |=> s_dav_release_then_sent) else $error("byte_sent not after DAV release");
	AST_DRIVE_GATE: assert property ((dio_n_oe || r.dav_pull) |-> talk_select) else $error("Talk drivers on without talk select");
	AST_SRQ_PULL: assert property (r.srq_s[1] |=> srq_n_oe) else $error("SRQ not pulled for service request");

endmodule

`default_nettype wire

// >>> gpib_bus_model.sv
// Purpose: Controller model for the far side of the handshake bus
// Assumes: Lines are low true and float high when nobody pulls them
// Notes:   A pull output at 1 drives its line low

`timescale 1ns/1ps
`default_nettype none

module gpib_bus_model (
	input  wire logic       clk,
	input  wire logic       dav,
	input  wire logic       nrfd,
	input  wire logic       ndac,
	input  wire logic [7:0] dio_n,
	output logic            atn_n,
	output logic            ifc_n,
	output logic            p_dav,
	output logic            p_nrfd,
	output logic            p_ndac,
	output logic [7:0]      p_dio_n
);
	logic early;
	int   n;

	// Idle: nothing pulled, data lines float high
	initial begin
		atn_n = 1'h1;
		ifc_n = 1'h1;
		p_dav = 1'h0;
		p_nrfd = 1'h0;
		p_ndac = 1'h0;
		p_dio_n = 8'hFF;
		early = 1'h0;
	end

	// -----------------------------------------------------------
	// Talker and listener sequences
	// -----------------------------------------------------------
	// Waits are bounded so a dead partner cannot hang the run
	// A floating bus is not a ready listener: wait for NRFD high with NDAC held low
	task send(input logic [7:0] b);
		p_dio_n <= ~b;
		for (n = 0; n < 300 && !(nrfd && !ndac); n++) @(posedge clk);
		@(posedge clk);
		p_dav <= 1'h1;
		@(posedge clk);
		for (n = 0; n < 300 && !ndac; n++) @(posedge clk);
		p_dav <= 1'h0;
		@(posedge clk);
		p_dio_n <= 8'hFF;
		@(posedge clk);
	endtask

	// Stall first for st cycles, noting any early data valid
	task rcv(input int st, output logic [7:0] b);
		p_nrfd <= 1'h1;
		p_ndac <= 1'h1;
		early = 1'h0;
		repeat (st) @(posedge clk) early |= !dav;
		p_nrfd <= 1'h0;
		for (n = 0; n < 300 && dav; n++) @(posedge clk);
		p_nrfd <= 1'h1;
		b = ~dio_n;
		@(posedge clk);
		p_ndac <= 1'h0;
		for (n = 0; n < 300 && !dav; n++) @(posedge clk);
		p_nrfd <= 1'h0;
		@(posedge clk);
	endtask
endmodule

`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the listen/talk/poll interface
// Assumes: Zero-wait register bus, two-stage input synchronisers
// Notes:   The peripheral is modelled by a small responder process

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        clk, rst_n, hwrite, capture_done, peripheral_hold, byte_ready, service_request_in;
	logic        hreadyout, hresp, dav_n_oe, nrfd_n_oe, ndac_n_oe, dio_n_oe, srq_n_oe;
	logic        hsel, dav_n_out, nrfd_n_out, ndac_n_out, srq_n_out;
	logic        listen_select, talk_select, poll_active, capture_strobe, byte_sent;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  in_data, out_data, dio_n_out, b;
	logic [31:0] haddr, hwdata, hrdata, r;
	wire         atn_n, ifc_n, m_dav, m_nrfd, m_ndac, dav, nrfd, ndac;
	wire  [7:0]  m_dio_n, dio;
	int          bad_count, checked, caps, sents;

	// Wired-AND of all pullers, pull-up otherwise
	assign dav = (dav_n_oe ? dav_n_out : 1'h1) & !m_dav;
	assign nrfd = (nrfd_n_oe ? nrfd_n_out : 1'h1) & !m_nrfd;
	assign ndac = (ndac_n_oe ? ndac_n_out : 1'h1) & !m_ndac;
	assign dio = (dio_n_oe ? dio_n_out : 8'hFF) & m_dio_n;

	gpib_iface DUT (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .atn_n, .ifc_n, .dav_n_in(dav),
		.dav_n_out, .dav_n_oe, .nrfd_n_in(nrfd), .nrfd_n_out, .nrfd_n_oe, .ndac_n_in(ndac),
		.ndac_n_out, .ndac_n_oe, .dio_n_in(dio), .dio_n_out, .dio_n_oe, .srq_n_out, .srq_n_oe,
		.listen_select, .talk_select, .poll_active, .in_data, .capture_strobe, .capture_done,
		.peripheral_hold, .out_data, .byte_ready, .byte_sent, .service_request_in);

	gpib_bus_model bus (.clk, .dav, .nrfd, .ndac, .dio_n(dio), .atn_n, .ifc_n,
		.p_dav(m_dav), .p_nrfd(m_nrfd), .p_ndac(m_ndac), .p_dio_n(m_dio_n));

	always #5 clk = ~clk;

	// Peripheral: answer each capture, drop ready once the byte is gone
	always @(posedge clk) begin
		capture_done <= capture_strobe;
		caps <= caps + int'(capture_strobe && !capture_done);
		sents <= sents + int'(byte_sent);
		if (byte_sent)
			byte_ready <= 1'h0;
	end

	// -----------------------------------------------------------
	// Bus cycles and comparisons
	// -----------------------------------------------------------
	task ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hsize <= gpib_iface_pkg::HSIZE_WORD;
		do @(posedge clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask

	task ck(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task rd(input logic [31:0] a, input logic [31:0] e);
		ahb(a, 1'h0, 32'h0);
		ck(r, e);
	endtask

	task wt(input int c);
		repeat (c) @(posedge clk);
	endtask

	task test_done;
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog, well beyond the few hundred cycles the tests need
	initial begin
		#300000;
		bad_count++;
		test_done;
	end

	// -----------------------------------------------------------
	// Test sequence
	// -----------------------------------------------------------
	initial begin
		{clk, rst_n, hwrite, peripheral_hold, byte_ready, service_request_in} = 6'h0;
		{haddr, hwdata, htrans, out_data, caps, sents} = 0;
		hsize = gpib_iface_pkg::HSIZE_WORD;
		hsel = 1'h1;
		capture_done = 1'h0;
		wt(3);
		rst_n <= 1'h1;
		wt(3);
		rd(gpib_iface_pkg::STATUS_OFF, 32'h0);
		rd(gpib_iface_pkg::CTRL_OFF, 32'h101);
		rd(32'h0C, 32'h0);
		ahb(gpib_iface_pkg::CTRL_OFF, 1'h1, 32'h105);
		rd(gpib_iface_pkg::CTRL_OFF, 32'h105);
		// A deselected write must leave the address alone
		hsel <= 1'h0;
		ahb(gpib_iface_pkg::CTRL_OFF, 1'h1, 32'h10A);
		hsel <= 1'h1;
		rd(gpib_iface_pkg::CTRL_OFF, 32'h105);
		bus.atn_n <= 1'h0;
		bus.send(8'h25);
		rd(gpib_iface_pkg::STATUS_OFF, 32'h2501);
		bus.atn_n <= 1'h1;
		wt(6);
		ck({listen_select, talk_select, dio_n_oe}, 32'h4);
		// Hold stalls the listener until released
		peripheral_hold <= 1'h1;
		wt(10);
		ck(nrfd, 32'h0);
		peripheral_hold <= 1'h0;
		foreach (out_data[i]) begin
			if (i < 2) begin
				bus.send(8'hA5 ^ i[7:0]);
				ck(in_data, 8'hA5 ^ i[7:0]);
			end
		end
		wt(6);
		ck({caps[7:0], ndac}, 32'h4);
		// Controller must get through even with the peripheral holding
		peripheral_hold <= 1'h1;
		bus.atn_n <= 1'h0;
		bus.send(8'h3F);
		rd(gpib_iface_pkg::STATUS_OFF, 32'h3F00);
		ck({caps[7:0], listen_select}, 32'h4);
		peripheral_hold <= 1'h0;
		bus.send(8'h45);
		bus.p_nrfd <= 1'h1;
		bus.p_ndac <= 1'h1;
		bus.atn_n <= 1'h1;
		wt(6);
		ck({talk_select, dio_n_oe}, 32'h3);
		out_data <= 8'h3C;
		wt(200);
		byte_ready <= 1'h1;
		bus.rcv(20, b);
		wt(4);
		ck({bus.early, b, sents[3:0], dav}, 32'h783);
		// Serial poll enable then disable
		bus.atn_n <= 1'h0;
		bus.send(8'h5F);
		bus.send(8'h18);
		rd(gpib_iface_pkg::STATUS_OFF, 32'h1807);
		ck(poll_active, 32'h1);
		bus.send(8'h19);
		rd(gpib_iface_pkg::STATUS_OFF, 32'h1900);
		// Interface clear while a listen address is remembered
		bus.send(8'h25);
		bus.ifc_n <= 1'h0;
		wt(4);
		bus.ifc_n <= 1'h1;
		bus.atn_n <= 1'h1;
		wt(6);
		ahb(gpib_iface_pkg::STATUS_OFF, 1'h0, 32'h0);
		ck({r[4:0], listen_select}, 32'h0);
		ahb(gpib_iface_pkg::RXDATA_OFF, 1'h1, 32'hFF);
		rd(gpib_iface_pkg::RXDATA_OFF, 32'h25);
		service_request_in <= 1'h1;
		wt(5);
		ck({srq_n_oe, srq_n_out}, 32'h2);
		service_request_in <= 1'h0;
		wt(5);
		ck(srq_n_oe, 32'h0);
		test_done;
	end
endmodule

`default_nettype wire
